// File: telegram_defs.svh
// constants for the telegram serial output path and its host receiver
// assumes a 100 MHz clock and a single reset shared by both ends
// Function
// R1: serial mode: forward each filtered telegram as block
// R2: empty learned table forwards every telegram
// R3: learned table: forward only matching transmitter ids
// R4: block is two sync, one header, data
// R5: 9600 bps, eight data bits, no parity
// R6: line rests high between characters
// R7: low start bit, eight bits lsb first
// R8: exactly one high stop bit per character
// R9: header length field counts following octets, eleven
// R10: checksum is low byte of non-sync sum
// R11: block octets back to back, never interleaved
`ifndef TELEGRAM_DEFS_SVH
`define TELEGRAM_DEFS_SVH
`define CLK_HZ          100000000
`define BAUD_BPS        9600
`define BIT_CYCLES      (`CLK_HZ / `BAUD_BPS)
`define HALF_BIT_CYCLES (`BIT_CYCLES / 2)
`define SYNC_HI         8'hA5
`define SYNC_LO         8'h5A
`define HSEQ_UNKNOWN    3'h0
`define HSEQ_KNOWN      3'h1
`define BLOCK_LEN       5'h0B
`define PAYLOAD_OCTETS  4'hA
`define LEARN_SLOTS     4
`endif

// File: telegram_pkg.sv
// types shared by both ends of the telegram serial link
// assumes telegram_defs.svh constants alongside
`default_nettype none
package telegram_pkg;
  typedef struct packed {
    logic [7:0]  org;
    logic [31:0] data;
    logic [31:0] id;
    logic [7:0]  status;
  } telegram_t;
  typedef enum logic [1:0] {ser_idle, ser_start, ser_bits, ser_stop} ser_state_t;
endpackage : telegram_pkg
`default_nettype wire

// File: telegram_link_if.sv
// serial line between the receiver module and the host
// assumes both ends share clk_in
`default_nettype none
interface telegram_link_if;
  logic line;
  modport dev  (output line);
  modport host (input line);
endinterface : telegram_link_if
`default_nettype wire

// File: telegram_tx.sv
// device end: filters received telegrams, frames blocks, sends them on the line
// assumes telegrams arrive on a valid/ready port in the same clock domain
`include "telegram_defs.svh"
`default_nettype none
module telegram_tx #(
  parameter int BIT_TICKS = `BIT_CYCLES
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   serial_mode_in,
  input  wire logic                   rx_valid_in,
  output logic                        rx_ready_out,
  input  wire telegram_pkg::telegram_t rx_telegram_in,
  input  wire logic                   learn_we_in,
  input  wire logic [1:0]             learn_slot_in,
  input  wire logic                   learn_valid_in,
  input  wire logic [31:0]            learn_id_in,
  output logic                        busy_out,
  telegram_link_if.dev                link
);
  logic [31:0]                 table_id_q [`LEARN_SLOTS];
  logic [`LEARN_SLOTS-1:0]     table_v_q;
  telegram_pkg::telegram_t     buf_q [2];
  logic                        wr_ptr_q;
  logic                        rd_ptr_q;
  logic [1:0]                  cnt_q;
  logic                        match;
  logic                        pass;
  logic                        buf_full;
  logic                        buf_empty;
  logic                        take;
  logic                        pop;
  telegram_pkg::telegram_t     cur_q;
  logic [3:0]                  oct_q;
  logic                        active_q;
  logic [7:0]                  sum_q;
  logic [7:0]                  octet;
  telegram_pkg::ser_state_t    st_q;
  logic [13:0]                 tick_q;
  logic [2:0]                  bit_q;
  logic [7:0]                  sh_q;
  logic                        line_q;
  logic                        ser_ready;
  logic                        load;
  logic                        last_oct;
  logic                        hdr_known;
  logic [7:0]                  hdr_octet;
  logic                        bit_end;
  logic                        chr_done;
  logic [13:0]                 tick_dec;
  logic [2:0]                  bit_nxt;

  // true when a valid table slot holds this transmitter id
  function automatic logic id_learned(logic [31:0] id);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < `LEARN_SLOTS; i++) begin
      if (table_v_q[i] && table_id_q[i] == id) hit = 1'b1;
    end
    return hit;
  endfunction : id_learned

  // forwarding filter on the offered telegram, header flag on the block being sent
  assign match     = id_learned(rx_telegram_in.id); // [R3]
  assign hdr_known = id_learned(cur_q.id); // [R3]
  assign hdr_octet = {(hdr_known ? `HSEQ_KNOWN : `HSEQ_UNKNOWN), `BLOCK_LEN}; // [R9]
  assign pass      = (table_v_q == '0) || match; // [R2] [R3]
  assign buf_full  = cnt_q == 2'd2;
  assign buf_empty = cnt_q == 2'd0;
  assign rx_ready_out = !buf_full || !serial_mode_in;
  assign take      = rx_valid_in && !buf_full && serial_mode_in && pass; // [R1]
  assign pop       = !buf_empty && !active_q;
  assign bit_end   = tick_q == '0;
  assign tick_dec  = tick_q - 14'd1;
  assign bit_nxt   = bit_q + 3'd1;
  // a character may start as the previous stop bit ends
  assign chr_done  = st_q == telegram_pkg::ser_stop && bit_end;
  assign ser_ready = st_q == telegram_pkg::ser_idle || chr_done; // [R11]
  assign load      = active_q && ser_ready;
  assign last_oct  = oct_q == `PAYLOAD_OCTETS + 4'd3;
  assign busy_out  = active_q || !buf_empty || st_q != telegram_pkg::ser_idle;

  // octet selection in block order
  always_comb begin
    unique case (oct_q) // [R4] [R9] [R10]
      4'd0:    octet = `SYNC_HI;
      4'd1:    octet = `SYNC_LO;
      4'd2:    octet = hdr_octet;
      4'd3:    octet = cur_q.org;
      4'd4:    octet = cur_q.data[31:24];
      4'd5:    octet = cur_q.data[23:16];
      4'd6:    octet = cur_q.data[15:8];
      4'd7:    octet = cur_q.data[7:0];
      4'd8:    octet = cur_q.id[31:24];
      4'd9:    octet = cur_q.id[23:16];
      4'd10:   octet = cur_q.id[15:8];
      4'd11:   octet = cur_q.id[7:0];
      4'd12:   octet = cur_q.status;
      default: octet = sum_q;
    endcase
  end

  // learned transmitter table
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      table_v_q <= '0;
      for (int i = 0; i < `LEARN_SLOTS; i++) table_id_q[i] <= '0;
    end else if (learn_we_in) begin
      table_v_q[learn_slot_in]  <= learn_valid_in;
      table_id_q[learn_slot_in] <= learn_id_in;
    end
  end

  // two-entry telegram buffer
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'd0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (take) begin
        buf_q[wr_ptr_q] <= rx_telegram_in;
        wr_ptr_q        <= !wr_ptr_q;
      end
      if (pop) rd_ptr_q <= !rd_ptr_q;
      cnt_q <= cnt_q + {1'b0, take} - {1'b0, pop};
    end
  end

  // block sequencer: a telegram's last octet is loaded into the serialiser before the next is taken
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      active_q <= 1'b0;
      cur_q    <= '0;
      oct_q    <= 4'd0;
      sum_q    <= 8'h00;
    end else if (pop) begin
      active_q <= 1'b1; // [R11]
      cur_q    <= buf_q[rd_ptr_q];
      oct_q    <= 4'd0;
      sum_q    <= 8'h00;
    end else if (load) begin
      oct_q <= oct_q + 4'd1; // [R11]
      if (oct_q >= 4'd2) sum_q <= sum_q + octet; // [R10]
      if (last_oct) active_q <= 1'b0;
    end
  end

  // character serialiser
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q   <= telegram_pkg::ser_idle;
      tick_q <= '0;
      bit_q  <= 3'd0;
      sh_q   <= 8'h00;
      line_q <= 1'b1; // [R6]
    end else begin
      unique case (st_q)
        telegram_pkg::ser_idle: begin
          line_q <= 1'b1; // [R6]
          if (load) begin
            sh_q   <= octet;
            tick_q <= 14'(BIT_TICKS - 1);
            line_q <= 1'b0; // [R7]
            st_q   <= telegram_pkg::ser_start;
          end
        end
        telegram_pkg::ser_start: begin
          if (bit_end) begin
            tick_q <= 14'(BIT_TICKS - 1); // [R5]
            line_q <= sh_q[0]; // [R7]
            bit_q  <= 3'd0;
            st_q   <= telegram_pkg::ser_bits;
          end else tick_q <= tick_dec;
        end
        telegram_pkg::ser_bits: begin
          if (bit_end) begin
            tick_q <= 14'(BIT_TICKS - 1);
            if (bit_q == 3'd7) begin
              line_q <= 1'b1; // [R8]
              st_q   <= telegram_pkg::ser_stop;
            end else begin
              line_q <= sh_q[bit_nxt]; // [R5] [R7]
              bit_q  <= bit_nxt;
            end
          end else tick_q <= tick_dec;
        end
        // next start bit follows the stop bit with no idle cycle
        telegram_pkg::ser_stop: begin
          if (chr_done && load) begin
            sh_q   <= octet;
            tick_q <= 14'(BIT_TICKS - 1);
            line_q <= 1'b0; // [R7] [R11]
            st_q   <= telegram_pkg::ser_start;
          end else if (chr_done) begin
            st_q   <= telegram_pkg::ser_idle; // [R8]
          end else tick_q <= tick_dec;
        end
      endcase
    end
  end

  assign link.line = line_q;
endmodule : telegram_tx
`default_nettype wire

// File: telegram_rx.sv
// host end: samples the serial line, rebuilds blocks, checks the checksum
// assumes the line is driven by telegram_tx; it is treated as an async pin
`include "telegram_defs.svh"
`default_nettype none
module telegram_rx #(
  parameter int BIT_TICKS = `BIT_CYCLES
) (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  telegram_link_if.host                link,
  output logic                         blk_valid_out,
  output telegram_pkg::telegram_t      blk_telegram_out,
  output logic [2:0]                   blk_hseq_out,
  output logic                         blk_err_out,
  output logic                         frame_err_out
);
  localparam int HALF_TICKS = BIT_TICKS / 2;
  logic                     s1_q, s2_q;
  telegram_pkg::ser_state_t st_q;
  logic [13:0]              tick_q;
  logic [2:0]               bit_q;
  logic [7:0]               sh_q;
  logic                     got_q;
  logic [7:0]               byte_q;
  logic [3:0]               idx_q;
  logic [7:0]               sum_q;
  logic [103:0]             acc_q;
  logic [7:0]               hdr_q;
  logic                     tick0;

  assign tick0 = tick_q == '0;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end else begin
      s1_q <= link.line;
      s2_q <= s1_q;
    end
  end

  // character sampler at bit centres
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_q          <= telegram_pkg::ser_idle;
      tick_q        <= '0;
      bit_q         <= 3'd0;
      sh_q          <= 8'h00;
      got_q         <= 1'b0;
      byte_q        <= 8'h00;
      frame_err_out <= 1'b0;
    end else begin
      got_q         <= 1'b0;
      frame_err_out <= 1'b0;
      unique case (st_q)
        telegram_pkg::ser_idle: begin
          if (!s2_q) begin // [R6] [R7]
            tick_q <= 14'(HALF_TICKS - 1);
            st_q   <= telegram_pkg::ser_start;
          end
        end
        telegram_pkg::ser_start: begin
          if (tick0) begin
            tick_q <= 14'(BIT_TICKS - 1); // [R5]
            bit_q  <= 3'd0;
            st_q   <= s2_q ? telegram_pkg::ser_idle : telegram_pkg::ser_bits;
          end else tick_q <= tick_q - 14'd1;
        end
        telegram_pkg::ser_bits: begin
          if (tick0) begin
            tick_q <= 14'(BIT_TICKS - 1);
            sh_q   <= {s2_q, sh_q[7:1]}; // [R7]
            bit_q  <= bit_q + 3'd1;
            if (bit_q == 3'd7) st_q <= telegram_pkg::ser_stop;
          end else tick_q <= tick_q - 14'd1;
        end
        telegram_pkg::ser_stop: begin
          if (tick0) begin
            st_q <= telegram_pkg::ser_idle;
            if (s2_q) begin // [R8]
              got_q  <= 1'b1;
              byte_q <= sh_q;
            end else frame_err_out <= 1'b1;
          end else tick_q <= tick_q - 14'd1;
        end
      endcase
    end
  end

  // block assembly
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_q            <= 4'd0;
      sum_q            <= 8'h00;
      acc_q            <= '0;
      hdr_q            <= 8'h00;
      blk_valid_out    <= 1'b0;
      blk_err_out      <= 1'b0;
      blk_telegram_out <= '0;
      blk_hseq_out     <= 3'd0;
    end else begin
      blk_valid_out <= 1'b0;
      if (frame_err_out) idx_q <= 4'd0;
      else if (got_q) begin
        unique case (idx_q)
          4'd0: idx_q <= (byte_q == `SYNC_HI) ? 4'd1 : 4'd0; // [R4]
          4'd1: idx_q <= (byte_q == `SYNC_LO) ? 4'd2 : ((byte_q == `SYNC_HI) ? 4'd1 : 4'd0);
          4'd2: begin
            hdr_q <= byte_q;
            sum_q <= byte_q;
            idx_q <= (byte_q[4:0] == `BLOCK_LEN) ? 4'd3 : 4'd0; // [R9]
          end
          4'd13: begin
            blk_valid_out    <= 1'b1;
            blk_err_out      <= byte_q != sum_q; // [R10]
            blk_telegram_out <= acc_q[79:0];
            blk_hseq_out     <= hdr_q[7:5];
            idx_q            <= 4'd0;
          end
          default: begin
            acc_q <= {acc_q[95:0], byte_q};
            sum_q <= sum_q + byte_q; // [R10]
            idx_q <= idx_q + 4'd1;
          end
        endcase
      end
    end
  end
endmodule : telegram_rx
`default_nettype wire

// File: telegram_link_asserts.sv
// assertions on the serial line joining the device end to the host end
// assumes the line is sampled on clk_in and rst_in is async, active high
`include "telegram_defs.svh"
`default_nettype none
module telegram_link_asserts #(
  parameter int BIT = `BIT_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       last_q;
  logic       in_frame_q;
  int         fcnt_q;
  int         chr_q;
  logic [7:0] sh_q;
  wire        start_w = !in_frame_q && !line && last_q;
  wire        end_w   = in_frame_q && fcnt_q == 10 * BIT - 1;
  wire        mid_w   = in_frame_q && fcnt_q > BIT && fcnt_q < 9 * BIT && fcnt_q % BIT == BIT / 2;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      last_q <= 1'b1;
      in_frame_q <= 1'b0;
      fcnt_q <= 0;
      chr_q <= 0;
      sh_q <= 8'h00;
    end else begin
      last_q <= line;
      in_frame_q <= start_w || (in_frame_q && !end_w);
      fcnt_q <= start_w ? 1 : fcnt_q + 1;
      chr_q <= end_w ? (chr_q == 13 ? 0 : chr_q + 1) : chr_q;
      sh_q <= mid_w ? {line, sh_q[7:1]} : sh_q;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_start_bit;
    in_frame_q && fcnt_q < BIT |-> !line;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit not low");
  property p_stop_bit;
    in_frame_q && fcnt_q >= 9 * BIT |-> line;
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("stop bit not high");
  property p_bit_stable;
    in_frame_q && fcnt_q % BIT != 0 |-> line == last_q;
  endproperty
  a_bit_stable: assert property (p_bit_stable) else $error("bit edge off bit time");
  property p_idle_high;
    !in_frame_q && !line |-> last_q;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low while idle");
  property p_back_to_back;
    end_w && chr_q != 13 |=> !line;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("gap inside block");
  property p_sync_first;
    end_w && chr_q == 0 |-> sh_q == `SYNC_HI;
  endproperty
  a_sync_first: assert property (p_sync_first) else $error("first sync octet wrong");
  property p_sync_second;
    end_w && chr_q == 1 |-> sh_q == `SYNC_LO;
  endproperty
  a_sync_second: assert property (p_sync_second) else $error("second sync wrong");
  property p_len_field;
    end_w && chr_q == 2 |-> sh_q[4:0] == `BLOCK_LEN;
  endproperty
  a_len_field: assert property (p_len_field) else $error("length field wrong");
endmodule : telegram_link_asserts
`default_nettype wire

// File: rx_telegram_serial_output_tb_top.sv
// testbench joining the device end and the host end over the link interface
// assumes the design files and telegram_defs.svh are compiled first
`include "telegram_defs.svh"
`default_nettype none
module rx_telegram_serial_output_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BIT  = 16; // shortened bit time keeps the run short
  localparam int HALF = BIT / 2;
  logic clk_in, rst_in, mode, valid, ready, busy, we, lvalid, bvalid, berr, ferr;
  logic [1:0]              slot;
  logic [31:0]             lid;
  logic [2:0]              hseq;
  telegram_pkg::telegram_t tel, btel;
  int                      n_mismatch, check_count, nblk, seed;
  telegram_link_if link ();
  telegram_tx #(.BIT_TICKS(BIT)) telegram_tx_i (.clk_in(clk_in), .rst_in(rst_in),
    .serial_mode_in(mode),
    .rx_valid_in(valid), .rx_ready_out(ready), .rx_telegram_in(tel), .learn_we_in(we),
    .learn_slot_in(slot), .learn_valid_in(lvalid), .learn_id_in(lid), .busy_out(busy),
    .link(link));
  telegram_rx #(.BIT_TICKS(BIT)) telegram_rx_i (.clk_in(clk_in), .rst_in(rst_in), .link(link),
    .blk_valid_out(bvalid), .blk_telegram_out(btel), .blk_hseq_out(hseq),
    .blk_err_out(berr), .frame_err_out(ferr));
  telegram_link_asserts #(.BIT(BIT)) telegram_link_asserts_i (.clk_in(clk_in),
    .rst_in(rst_in), .line(link.line));
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up
  task automatic check(string what, logic [79:0] seen, logic [79:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(inout int n, input int lim);
    @(negedge clk_in);
    n++;
    if (n > lim) begin
      n_mismatch++;
      $display("Error wait timed out");
      wrap_up();
    end
  endtask : tick
  always @(negedge clk_in) begin
    if (bvalid === 1'b1) nblk++;
    if (ferr === 1'b1) check("frame_err", ferr, 0);
  end
  function automatic telegram_pkg::telegram_t rnd_tel();
    logic [95:0] r;
    r = {$random(seed), $random(seed), $random(seed)};
    return r[79:0];
  endfunction : rnd_tel
  function automatic logic [7:0] exp_byte(telegram_pkg::telegram_t t, logic [2:0] h, int i);
    logic [87:0] body;
    logic [7:0]  sum;
    body = {h, `BLOCK_LEN, t};
    sum = 8'h00;
    for (int k = 0; k < 11; k++) sum += body[8*k +: 8];
    if (i == 0) return `SYNC_HI;
    if (i == 1) return `SYNC_LO;
    if (i == 13) return sum;
    return body[87 - 8 * (i - 2) -: 8];
  endfunction : exp_byte
  task automatic get_char(output logic [7:0] b);
    int n;
    n = 0;
    while (link.line !== 1'b0) tick(n, 4 * BIT);
    repeat (HALF) @(negedge clk_in);
    check("start_bit", link.line, 0);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(negedge clk_in);
      b[i] = link.line;
    end
    repeat (BIT) @(negedge clk_in);
    check("stop_bit", link.line, 1);
  endtask : get_char
  task automatic check_block(telegram_pkg::telegram_t t, logic [2:0] h);
    logic [7:0] b;
    int         n0;
    n0 = nblk;
    for (int i = 0; i < 14; i++) begin
      get_char(b);
      check("octet", b, exp_byte(t, h, i));
    end
    for (int i = 0; i < 4 * BIT && nblk == n0; i++) @(negedge clk_in);
    check("blk_count", nblk, n0 + 1);
    check("blk_telegram", btel, t);
    check("blk_hseq", hseq, h);
    check("blk_err", berr, 0);
  endtask : check_block
  task automatic offer(telegram_pkg::telegram_t t);
    int n;
    n = 0;
    tel = t;
    valid = 1'b1;
    while (ready !== 1'b1) tick(n, 100);
    @(negedge clk_in);
  endtask : offer
  task automatic learn(logic [1:0] s, logic [31:0] id, logic v);
    slot = s;
    lid = id;
    lvalid = v;
    we = 1'b1;
    @(negedge clk_in);
    we = 1'b0;
    @(negedge clk_in);
  endtask : learn
  initial begin
    telegram_pkg::telegram_t a, b, y;
    seed = 32'h30be_16b7;
    n_mismatch = 0;
    check_count = 0;
    nblk = 0;
    rst_in = 1'b1;
    mode = 1'b1;
    valid = 1'b0;
    tel = '0;
    we = 1'b0;
    slot = 2'h0;
    lvalid = 1'b0;
    lid = 32'h0000_0000;
    repeat (4) @(negedge clk_in);
    rst_in = 1'b0;
    check("idle_line", link.line, 1);
    check("ready", ready, 1);
    a = '1;
    offer(a);
    valid = 1'b0;
    check_block(a, `HSEQ_UNKNOWN);
    $display("test empty_table done");
    a = rnd_tel();
    b = rnd_tel();
    y = rnd_tel();
    b.id = a.id + 1;
    y.id = a.id + 2;
    learn(2'h0, a.id, 1'b1);
    learn(2'h1, b.id, 1'b1);
    learn(2'h2, y.id, 1'b0);
    offer(y);
    offer(a);
    offer(b);
    valid = 1'b0;
    check_block(a, `HSEQ_KNOWN);
    check_block(b, `HSEQ_KNOWN);
    $display("test learned_filter done");
    mode = 1'b0;
    offer(rnd_tel());
    valid = 1'b0;
    repeat (2 * BIT) @(negedge clk_in);
    check("busy", busy, 0);
    check("idle_line", link.line, 1);
    $display("test non_serial done");
    wrap_up();
  end
endmodule : rx_telegram_serial_output_tb_top
`default_nettype wire
